// ===== rtl/lcrs_pkg.sv
// package of the common-driver row scanner: timing counts, register map, carrier types
// assumes a 10 MHz pclk; every slower rate is derived from it as an enable pulse
package lcrs_pkg;

    // clock and oscillator rates
    localparam int CLK_HZ = 10_000_000;
    localparam int OSC_HI_HZ = 430_000;
    localparam int OSC_LO_HZ = 215_000;
    localparam int FRAME_HZ = 70;
    localparam int OSC_DIV_HI = CLK_HZ / OSC_HI_HZ;
    localparam int OSC_DIV_LO = CLK_HZ / OSC_LO_HZ;

    // scan geometry and duty settings (rows per frame)
    localparam int STAGES = 64;
    localparam int DUTY_48 = 48;
    localparam int DUTY_64 = 64;
    localparam int DUTY_96 = 96;
    localparam int DUTY_128 = 128;

    // oscillator ticks per row, per oscillator range and duty (rounded down)
    localparam int TICKS_HI_48 = OSC_HI_HZ / (FRAME_HZ * DUTY_48);
    localparam int TICKS_HI_64 = OSC_HI_HZ / (FRAME_HZ * DUTY_64);
    localparam int TICKS_HI_96 = OSC_HI_HZ / (FRAME_HZ * DUTY_96);
    localparam int TICKS_HI_128 = OSC_HI_HZ / (FRAME_HZ * DUTY_128);
    localparam int TICKS_LO_48 = OSC_LO_HZ / (FRAME_HZ * DUTY_48);
    localparam int TICKS_LO_64 = OSC_LO_HZ / (FRAME_HZ * DUTY_64);
    localparam int TICKS_LO_96 = OSC_LO_HZ / (FRAME_HZ * DUTY_96);
    localparam int TICKS_LO_128 = OSC_LO_HZ / (FRAME_HZ * DUTY_128);

    // segment phase clock: quarter period, least time rounded up to cycles
    localparam int PHASE_NS = 700;
    localparam int PHASE_CYC = (PHASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // register map (byte addresses) and fields
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int ST_MASTER_BIT = 0;
    localparam int ST_AC_BIT = 1;
    localparam int ST_CLK_BIT = 2;
    localparam int ST_ROW_LSB = 8;
    localparam int ST_FRAMES_LSB = 16;

    // strap pins, carried together
    typedef struct packed {
        logic master_slave_select;
        logic shift_dir_select;
        logic shift_edge_select;
        logic osc_range_select;
        logic duty_select_hi;
        logic duty_select_lo;
    } lcrs_straps_t;

    localparam lcrs_straps_t STRAPS_RST = '0;

    // bias level chosen for one common line
    typedef enum logic [1:0] {
        LCRS_V0 = 2'h0,
        LCRS_V1 = 2'h1,
        LCRS_V4 = 2'h2,
        LCRS_V5 = 2'h3
    } lcrs_bias_t;

    // master row timing states
    typedef enum logic [2:0] {
        LCRS_IDLE = 3'b001,
        LCRS_LOW = 3'b010,
        LCRS_HIGH = 3'b100
    } lcrs_state_t;

    // level of a common line from its stage data and the inversion signal
    function automatic lcrs_bias_t lcrs_bias_of(input logic data, input logic inv);
        lcrs_bias_t b;
        b = LCRS_V1;
        case ({data, inv})
            2'b00: b = LCRS_V1;
            2'b01: b = LCRS_V4;
            2'b10: b = LCRS_V5;
            2'b11: b = LCRS_V0;
            default: b = LCRS_V1;
        endcase
        return b;
    endfunction

endpackage

// ===== rtl/lcrs_scanner.sv
// row scanner of a 64-line dot-matrix common driver, with an APB register port
// assumes straps and link pins are asynchronous to pclk; the bench resolves the
// two-way pins from the _o/_oe pairs
//
// Function
// RL1: master mode drives both chain pins, row shift clock and inversion signal
// RL2: slave mode: chain pin at entry end is input, other end output
// RL3: slave mode takes row shift clock and inversion from the outside controller
// RL4: direction high shifts a to stage 1..64 to b, low the reverse
// RL5: 64-stage scan register whose stages set the common line levels
// RL6: shift on rising row clock edge if edge select high, else falling
// RL7: master frame of 70 Hz from 430 kHz or 215 kHz oscillator
// RL8: master duty from two selects: 48, 64, 96 or 128 rows
// RL9: in slave mode the outside ties duty and range selects high
// RL10: master drives two segment phase clocks, slave leaves them quiet
// RL11: master drives frame sync, slave leaves it quiet
// RL12: inversion signal driven in master, received in slave
// RL13: row shift clock driven in master, received in slave
// RL14: level from data and inversion: 00 V1, 01 V4, 10 V5, 11 V0
// RL15: master injects one token per frame and shifts it once per row
`timescale 1ns/1ps
module lcrs_scanner #(
    parameter int STAGES_N = lcrs_pkg::STAGES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap pins
    input wire lcrs_pkg::lcrs_straps_t straps,
    // chain pins and shared timing pins, each as in/out/enable
    input wire logic chain_io_a_i,
    output logic chain_io_a_o,
    output logic chain_io_a_oe,
    input wire logic chain_io_b_i,
    output logic chain_io_b_o,
    output logic chain_io_b_oe,
    input wire logic row_shift_clk_i,
    output logic row_shift_clk_o,
    output logic row_shift_clk_oe,
    input wire logic ac_invert_i,
    output logic ac_invert_o,
    output logic ac_invert_oe,
    // segment driver timing outputs
    output logic seg_phase_clk_a,
    output logic seg_phase_clk_b,
    output logic frame_sync,
    // common line levels, index 0 is line 1
    output lcrs_pkg::lcrs_bias_t common_outputs [STAGES_N]
);
    import lcrs_pkg::*;

    // the chain shifts through both ends, so anything below two stages is meaningless
    if (STAGES_N < 2) begin : g_bad_stages
        $error("lcrs_scanner: STAGES_N must be at least 2");
    end

    // two-flop synchronisers for straps and link pins; stage one feeds stage two only
    lcrs_straps_t strap_s1_r;
    lcrs_straps_t strap_s2_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic clk_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_r <= STRAPS_RST;
            strap_s2_r <= STRAPS_RST;
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            clk_prev_r <= 1'b0;
        end else begin
            strap_s1_r <= straps;
            strap_s2_r <= strap_s1_r;
            pin_s1_r <= {row_shift_clk_i, ac_invert_i, chain_io_a_i, chain_io_b_i};
            pin_s2_r <= pin_s1_r;
            clk_prev_r <= pin_s2_r[3];
        end
    end

    logic master;
    logic dir_up;
    logic edge_rise;
    logic slave_clk;
    logic slave_ac;
    logic slave_a;
    logic slave_b;
    assign master = strap_s2_r.master_slave_select;
    assign dir_up = strap_s2_r.shift_dir_select;
    assign edge_rise = strap_s2_r.shift_edge_select;
    assign slave_clk = pin_s2_r[3];
    assign slave_ac = pin_s2_r[2];
    assign slave_a = pin_s2_r[1];
    assign slave_b = pin_s2_r[0];

    // control register bit that lets software hold the master timing
    logic run_en_r;
    logic run;
    assign run = master & run_en_r;

    // duty and per-row tick count; slave straps are don't-care here
    logic [7:0] duty_rows;
    logic [7:0] row_ticks;
    logic [5:0] osc_div;
    always_comb begin
        duty_rows = 8'(DUTY_48);
        row_ticks = 8'(TICKS_HI_48);
        osc_div = strap_s2_r.osc_range_select ? 6'(OSC_DIV_HI) : 6'(OSC_DIV_LO); // see RL7
        case ({strap_s2_r.duty_select_hi, strap_s2_r.duty_select_lo}) // see RL8
            2'b00: begin
                duty_rows = 8'(DUTY_48);
                row_ticks = strap_s2_r.osc_range_select ? 8'(TICKS_HI_48) : 8'(TICKS_LO_48);
            end
            2'b01: begin
                duty_rows = 8'(DUTY_64);
                row_ticks = strap_s2_r.osc_range_select ? 8'(TICKS_HI_64) : 8'(TICKS_LO_64);
            end
            2'b10: begin
                duty_rows = 8'(DUTY_96);
                row_ticks = strap_s2_r.osc_range_select ? 8'(TICKS_HI_96) : 8'(TICKS_LO_96);
            end
            2'b11: begin
                duty_rows = 8'(DUTY_128);
                row_ticks = strap_s2_r.osc_range_select ? 8'(TICKS_HI_128) : 8'(TICKS_LO_128);
            end
            default: begin
                duty_rows = 8'(DUTY_48);
                row_ticks = 8'(TICKS_HI_48);
            end
        endcase
    end

    // master row timing: oscillator enable, row clock low/high halves, row and frame count
    lcrs_state_t state_r;
    lcrs_state_t state_nxt;
    logic [5:0] div_r;
    logic [5:0] div_nxt;
    logic [7:0] tick_r;
    logic [7:0] tick_nxt;
    logic [6:0] row_r;
    logic [6:0] row_nxt;
    logic ac_r;
    logic ac_nxt;
    logic [15:0] frames_r;
    logic [15:0] frames_nxt;
    logic osc_tick;
    logic rise_m;
    logic fall_m;

    always_comb begin
        state_nxt = state_r;
        tick_nxt = tick_r;
        row_nxt = row_r;
        ac_nxt = ac_r;
        frames_nxt = frames_r;
        rise_m = 1'b0;
        fall_m = 1'b0;
        osc_tick = (div_r == 6'h00);
        div_nxt = osc_tick ? (osc_div - 6'h01) : (div_r - 6'h01);
        case (state_r)
            LCRS_IDLE: begin
                tick_nxt = 8'h00;
                row_nxt = 7'h00;
                if (run) begin
                    state_nxt = LCRS_LOW;
                end
            end
            LCRS_LOW: begin
                if (!run) begin
                    state_nxt = LCRS_IDLE;
                end else if (osc_tick) begin
                    tick_nxt = tick_r + 8'h01;
                    if (tick_r == (row_ticks >> 1) - 8'h01) begin
                        state_nxt = LCRS_HIGH;
                        rise_m = 1'b1;
                    end
                end
            end
            LCRS_HIGH: begin
                if (!run) begin
                    state_nxt = LCRS_IDLE;
                end else if (osc_tick) begin
                    tick_nxt = tick_r + 8'h01;
                    if (tick_r >= row_ticks - 8'h01) begin
                        // one row per row clock period; frame wraps at the duty count
                        tick_nxt = 8'h00;
                        state_nxt = LCRS_LOW;
                        fall_m = 1'b1;
                        if ({1'b0, row_r} >= duty_rows - 8'h01) begin // see RL8
                            row_nxt = 7'h00;
                            ac_nxt = ~ac_r; // see RL12
                            frames_nxt = frames_r + 16'h0001;
                        end else begin
                            row_nxt = row_r + 7'h01;
                        end
                    end
                end
            end
            default: state_nxt = LCRS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= LCRS_IDLE;
            div_r <= 6'h00;
            tick_r <= 8'h00;
            row_r <= 7'h00;
            ac_r <= 1'b0;
            frames_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            row_r <= row_nxt;
            ac_r <= ac_nxt;
            frames_r <= frames_nxt;
        end
    end

    // scan shift register; stage 0 drives line 1
    logic [STAGES_N-1:0] stages_r;
    logic [STAGES_N-1:0] stages_nxt;
    logic shift_ev;
    logic token;
    logic din;
    logic ac_now;

    always_comb begin
        token = (row_r == 7'h00); // see RL15
        ac_now = master ? ac_r : slave_ac; // see RL3
        if (master) begin
            shift_ev = edge_rise ? rise_m : fall_m; // see RL6
            din = token;
        end else begin
            // slave edges come from the synchronised pin, so they lag it by about 3 cycles
            shift_ev = edge_rise ? (slave_clk & ~clk_prev_r) : (~slave_clk & clk_prev_r); // see RL6
            din = dir_up ? slave_a : slave_b; // see RL2
        end
        stages_nxt = stages_r;
        if (shift_ev) begin
            stages_nxt = dir_up ? {stages_r[STAGES_N-2:0], din} : {din, stages_r[STAGES_N-1:1]}; // see RL4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stages_r <= '0;
        end else begin
            stages_r <= stages_nxt; // see RL5
        end
    end

    // common line levels, one flop pair per line
    lcrs_bias_t lvl_nxt [STAGES_N];
    for (genvar gi = 0; gi < STAGES_N; gi++) begin : g_line
        always_comb begin
            lvl_nxt[gi] = lcrs_bias_of(stages_r[gi], ac_now); // see RL14
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                common_outputs[gi] <= LCRS_V1;
            end else begin
                common_outputs[gi] <= lvl_nxt[gi];
            end
        end
    end

    // segment phase clocks: four 700 ns quarters, each clock low in its own quarter
    logic [3:0] ph_cnt_r;
    logic [3:0] ph_cnt_nxt;
    logic [1:0] ph_idx_r;
    logic [1:0] ph_idx_nxt;
    always_comb begin
        ph_cnt_nxt = ph_cnt_r + 4'h1;
        ph_idx_nxt = ph_idx_r;
        if (!run) begin
            ph_cnt_nxt = 4'h0;
            ph_idx_nxt = 2'h0;
        end else if (ph_cnt_r == 4'(PHASE_CYC - 1)) begin
            ph_cnt_nxt = 4'h0;
            ph_idx_nxt = ph_idx_r + 2'h1;
        end
    end

    // pin and timing outputs, registered; slave leaves the segment outputs low
    logic chain_a_o_nxt;
    logic chain_b_o_nxt;
    always_comb begin
        if (master) begin
            chain_a_o_nxt = dir_up ? token : stages_r[0]; // see RL1
            chain_b_o_nxt = dir_up ? stages_r[STAGES_N-1] : token; // see RL1
        end else begin
            chain_a_o_nxt = stages_r[0];
            chain_b_o_nxt = stages_r[STAGES_N-1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_cnt_r <= 4'h0;
            ph_idx_r <= 2'h0;
            chain_io_a_o <= 1'b0;
            chain_io_a_oe <= 1'b0;
            chain_io_b_o <= 1'b0;
            chain_io_b_oe <= 1'b0;
            row_shift_clk_o <= 1'b0;
            row_shift_clk_oe <= 1'b0;
            ac_invert_o <= 1'b0;
            ac_invert_oe <= 1'b0;
            seg_phase_clk_a <= 1'b0;
            seg_phase_clk_b <= 1'b0;
            frame_sync <= 1'b0;
        end else begin
            ph_cnt_r <= ph_cnt_nxt;
            ph_idx_r <= ph_idx_nxt;
            chain_io_a_o <= chain_a_o_nxt;
            chain_io_a_oe <= master | ~dir_up; // see RL1 see RL2
            chain_io_b_o <= chain_b_o_nxt;
            chain_io_b_oe <= master | dir_up; // see RL1 see RL2
            row_shift_clk_o <= (state_r == LCRS_HIGH); // see RL13
            row_shift_clk_oe <= master; // see RL13
            ac_invert_o <= ac_r; // see RL12
            ac_invert_oe <= master; // see RL12
            seg_phase_clk_a <= run & (ph_idx_r != 2'h0); // see RL10
            seg_phase_clk_b <= run & (ph_idx_r != 2'h2); // see RL10
            frame_sync <= run & token; // see RL11
        end
    end

    // apb slave: zero wait states, read data captured in the setup cycle
    logic apb_setup;
    logic apb_wr;
    logic run_en_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt;
    logic pslverr_nxt;
    logic [31:0] status_word;
    always_comb begin
        apb_setup = psel & ~penable;
        apb_wr = psel & penable & pready & pwrite;
        status_word = 32'h0000_0000;
        status_word[ST_MASTER_BIT] = master;
        status_word[ST_AC_BIT] = ac_now;
        status_word[ST_CLK_BIT] = master ? (state_r == LCRS_HIGH) : slave_clk;
        status_word[ST_ROW_LSB +: 7] = row_r;
        status_word[ST_FRAMES_LSB +: 16] = frames_r;
        run_en_nxt = run_en_r;
        if (apb_wr && paddr == ADDR_CTRL) begin
            run_en_nxt = pwdata[CTRL_RUN_BIT];
        end
        pready_nxt = apb_setup;
        pslverr_nxt = apb_setup & (paddr != ADDR_CTRL) & (paddr != ADDR_STATUS);
        prdata_nxt = prdata;
        if (apb_setup) begin
            case (paddr)
                ADDR_CTRL: prdata_nxt = {31'h0000_0000, run_en_r};
                ADDR_STATUS: prdata_nxt = status_word;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_en_r <= CTRL_RUN_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            run_en_r <= run_en_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

endmodule

// ===== sim/lcrs_scanner_props.sv
// checker of the row scanner: pin directions, phase clocks, levels, apb answers
// assumes it is bound to lcrs_scanner and sees only its ports
`timescale 1ns/1ps
module lcrs_scanner_props #(
    parameter int STAGES_N = 64
) (
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // straps, pins and lines
    input wire lcrs_pkg::lcrs_straps_t straps,
    input wire logic chain_io_a_o,
    input wire logic chain_io_a_oe,
    input wire logic chain_io_b_oe,
    input wire logic row_shift_clk_oe,
    input wire logic ac_invert_oe,
    input wire logic seg_phase_clk_a,
    input wire logic seg_phase_clk_b,
    input wire logic frame_sync,
    input wire lcrs_pkg::lcrs_bias_t common_outputs [STAGES_N]
);
    import lcrs_pkg::*;
    logic [2:0] settle_r;
    logic [2:0] settle_nxt;
    lcrs_straps_t last_r;
    logic settled;
    logic ms;
    logic dir;
    logic lo_first;
    logic lo_last;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // straps pass two flops, so pin checks wait until they sat still a while
    always_comb begin
        settle_nxt = settle_r;
        if (straps != last_r) begin
            settle_nxt = 3'h0;
        end else if (settle_r != 3'h7) begin
            settle_nxt = settle_r + 3'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_r <= 3'h0;
            last_r <= STRAPS_RST;
        end else begin
            settle_r <= settle_nxt;
            last_r <= straps;
        end
    end
    // every line shares one inversion state, so both ends must agree
    assign settled = (settle_r == 3'h7);
    assign ms = straps.master_slave_select;
    assign dir = straps.shift_dir_select;
    assign lo_first = common_outputs[0] == LCRS_V1 || common_outputs[0] == LCRS_V5;
    assign lo_last = common_outputs[STAGES_N-1] == LCRS_V1 || common_outputs[STAGES_N-1] == LCRS_V5;
    chk_master_drive: assert property (settled && ms |->
        chain_io_a_oe && chain_io_b_oe && row_shift_clk_oe && ac_invert_oe)
        else $error("master mode left a link pin undriven");
    chk_slave_dir: assert property (settled && !ms |->
        chain_io_a_oe == !dir && chain_io_b_oe == dir)
        else $error("slave chain pin direction wrong");
    chk_slave_listen: assert property (settled && !ms |->
        !row_shift_clk_oe && !ac_invert_oe)
        else $error("slave drives row clock or inversion");
    chk_slave_quiet: assert property (settled && !ms |->
        !(seg_phase_clk_a || seg_phase_clk_b || frame_sync))
        else $error("slave drives segment timing");
    chk_phase_gap: assert property ($fell(seg_phase_clk_a) |->
        seg_phase_clk_b ##1 !seg_phase_clk_a [*6] ##1 seg_phase_clk_a)
        else $error("phase clock low width or overlap wrong");
    chk_frame_entry: assert property ($rose(frame_sync) && dir |->
        ##[0:2] chain_io_a_o)
        else $error("frame start not shown at entry pin");
    chk_bias_share: assert property (lo_first == lo_last)
        else $error("lines disagree on inversion");
    chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single pulse after setup");
    chk_apb_unmapped: assert property (psel && !penable && paddr != ADDR_CTRL &&
        paddr != ADDR_STATUS |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    cov_frame: cover property ($rose(frame_sync));
    cov_phase: cover property ($rose(seg_phase_clk_b));
    cov_refuse: cover property (pslverr);
endmodule
bind lcrs_scanner lcrs_scanner_props #(.STAGES_N(STAGES_N)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .straps(straps),
    .chain_io_a_o(chain_io_a_o), .chain_io_a_oe(chain_io_a_oe),
    .chain_io_b_oe(chain_io_b_oe), .row_shift_clk_oe(row_shift_clk_oe),
    .ac_invert_oe(ac_invert_oe), .seg_phase_clk_a(seg_phase_clk_a),
    .seg_phase_clk_b(seg_phase_clk_b), .frame_sync(frame_sync),
    .common_outputs(common_outputs));

// ===== sim/lcrs_ctrl_model.sv
// outside controller that feeds a slave scanner: row clock, inversion, chain data
// assumes the bench resolves its lines against the scanner's enables
`timescale 1ns/1ps
module lcrs_ctrl_model (
    // link lines toward the scanner
    output logic row_shift_clk,
    output logic ac_invert,
    output logic chain_data
);
    // clock parks low between frames
    initial begin
        row_shift_clk = 1'b0;
        ac_invert = 1'b0;
        chain_data = 1'b1;
    end
    task automatic set_ac(input logic v);
        ac_invert <= v;
    endtask
    // one bit per 800 ns; data moves only at the unused edge to keep 400 ns margins
    task automatic shift(input logic b, input logic rise);
        chain_data <= b;
        if (rise) begin
            #400 row_shift_clk <= 1'b1;
            #400 row_shift_clk <= 1'b0;
        end else begin
            row_shift_clk <= 1'b1;
            #400 row_shift_clk <= 1'b0;
            #400;
        end
    endtask
    // released line no longer holds the last bit
    task automatic idle_data;
        chain_data <= ~chain_data;
    endtask
endmodule

// ===== sim/lcrs_scanner_test.sv
// self-checking bench of the row scanner: apb, slave shifting, master timing
// assumes the controller model stands on the link pins in slave mode
`timescale 1ns/1ps
module lcrs_scanner_test;
    import lcrs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    lcrs_straps_t straps = '0;
    logic a_o, a_oe, b_o, b_oe, c_o, c_oe, m_o, m_oe, ph_a, ph_b, fsync;
    logic m_clk, m_ac, m_dat, a_w, b_w, c_w, ac_w;
    lcrs_bias_t lines [STAGES];
    int errors = 0, cmp_count = 0;
    always #50 pclk = ~pclk;
    // wire levels from whichever side drives
    assign a_w = a_oe ? a_o : m_dat;
    assign b_w = b_oe ? b_o : m_dat;
    assign c_w = c_oe ? c_o : m_clk;
    assign ac_w = m_oe ? m_o : m_ac;
    lcrs_ctrl_model i_ctrl (.row_shift_clk(m_clk), .ac_invert(m_ac), .chain_data(m_dat));
    lcrs_scanner i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .straps(straps), .chain_io_a_i(a_w), .chain_io_a_o(a_o),
        .chain_io_a_oe(a_oe), .chain_io_b_i(b_w), .chain_io_b_o(b_o), .chain_io_b_oe(b_oe),
        .row_shift_clk_i(c_w), .row_shift_clk_o(c_o), .row_shift_clk_oe(c_oe),
        .ac_invert_i(ac_w), .ac_invert_o(m_o), .ac_invert_oe(m_oe), .seg_phase_clk_a(ph_a),
        .seg_phase_clk_b(ph_b), .frame_sync(fsync), .common_outputs(lines));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task do_reset(input lcrs_straps_t s);
        @(posedge pclk);
        presetn <= 1'b0;
        straps <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
    // setup, then access held until ready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("Error at %0t: no ready", $time);
            end_sim;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_apb;
        logic [31:0] rd;
        logic err;
        do_reset(6'h1F);
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        check(rd[CTRL_RUN_BIT], CTRL_RUN_RST);
        apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
        check(err, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        check(rd[CTRL_RUN_BIT], 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check(rd[ST_MASTER_BIT], 1'b0);
        apb(1'b1, 8'h08, 32'hFFFFFFFF, rd, err);
        check(err, 1'b1);
        apb(1'b0, 8'h08, 32'h0, rd, err);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("apb test done");
    endtask
    task t_slave(input logic dir, input logic rise);
        int idx;
        int nb;
        logic [31:0] rd;
        logic err;
        idx = dir ? 4 : STAGES - 5;
        nb = dir ? 3 : STAGES - 4;
        do_reset({1'b0, dir, rise, 3'b111});
        i_ctrl.set_ac(1'b0);
        i_ctrl.shift(1'b1, rise);
        repeat (4) i_ctrl.shift(1'b0, rise);
        repeat (6) @(posedge pclk);
        check(lines[idx], LCRS_V5);
        check(lines[nb], LCRS_V1);
        i_ctrl.set_ac(1'b1);
        repeat (10) @(posedge pclk);
        check(lines[idx], LCRS_V0);
        check(lines[nb], LCRS_V4);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check(rd[ST_AC_BIT], 1'b1);
        repeat (STAGES - 5) i_ctrl.shift(1'b0, rise);
        i_ctrl.idle_data();
        repeat (6) @(posedge pclk);
        check(lines[dir ? STAGES - 1 : 0], LCRS_V0);
        check(dir ? b_w : a_w, 1'b1);
        $display("slave test done dir %0d edge %0d", dir, rise);
    endtask
    task wait_rise(output int n);
        n = 0;
        while (c_w === 1'b1 && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        while (c_w !== 1'b1 && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 9000) begin
            errors++;
            $display("Error at %0t: row clock stalled", $time);
            end_sim;
        end
    endtask
    task t_master(input logic fs, input logic [1:0] ds);
        int n, osc, rows, sel;
        osc = fs ? OSC_HI_HZ : OSC_LO_HZ;
        rows = ds == 2'b00 ? DUTY_48 : ds == 2'b01 ? DUTY_64 : ds == 2'b10 ? DUTY_96 : DUTY_128;
        do_reset({1'b1, ~fs, ~ds[0], fs, ds});
        wait_rise(n);
        check(fsync, 1'b1);
        check(ac_w, 1'b0);
        wait_rise(n);
        check(n, osc / (FRAME_HZ * rows) * (CLK_HZ / osc));
        check(fsync, 1'b0);
        repeat (4) @(posedge pclk);
        sel = 0;
        foreach (lines[i]) if (lines[i] == LCRS_V5 || lines[i] == LCRS_V0) sel++;
        check(sel, 1);
        $display("master test done range %0d duty %0d", fs, rows);
    endtask
    initial begin
        t_apb();
        for (int d = 0; d < 4; d++) t_slave(d[1], d[0]);
        for (int m = 0; m < 8; m++) t_master(m[2], m[1:0]);
        end_sim();
    end
endmodule
